// file: hdl/bbi_top.sv
// staging fifo between the controller write port and the banks
module bbi_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic IN_VALID,
   input wire logic [WIDTH-1:0] IN_DATA,
   output logic IN_READY,
   output logic OUT_VALID,
   output logic [WIDTH-1:0] OUT_DATA,
   input wire logic OUT_READY
);
   import bbi_pkg::*;
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic full;
   logic empty;

   assign empty = (wr_ptr == rd_ptr);
   assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign IN_READY = !full;
   assign OUT_VALID = !empty;
   assign OUT_DATA = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge CLK) begin
      if (IN_VALID && !full) begin
         mem[wr_ptr[AW-1:0]] <= IN_DATA;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         wr_ptr <= '0;
      end else if (IN_VALID && !full) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         rd_ptr <= '0;
      end else if (OUT_READY && !empty) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule

module bbi_top (
   input wire logic CLK,
   input wire logic RST,
   input wire logic WR_VALID,
   input wire logic [bbi_pkg::DATA_W-1:0] WR_DATA,
   input wire logic WR_LAST,
   output logic WR_READY,
   input wire logic TX_IRQ_EN,
   output logic IRQ_OUT,
   output logic PKT_READY_FLAG,
   input wire logic IN_TOKEN,
   output logic TX_VALID,
   output logic [bbi_pkg::DATA_W-1:0] TX_DATA,
   output logic TX_LAST,
   input wire logic TX_READY,
   output logic TX_NAK,
   input wire logic HS_ACK,
   input wire logic HS_TIMEOUT,
   input wire logic RX_DONE,
   input wire logic RX_BAD,
   output logic RX_ACK,
   output logic RX_NOTIFY
);
   import bbi_pkg::*;

   logic [DATA_W-1:0] bank_mem [2][BANK_BYTES];
   logic [CNT_W-1:0] bank_len [2];
   logic [1:0] ready;
   logic fill_bank;
   logic send_bank;
   logic [CNT_W-1:0] fill_cnt;
   logic [CNT_W-1:0] idx;
   bbi_state_type state;
   bbi_state_type next_state;

   logic f_valid;
   logic [DATA_W:0] f_data;
   logic drain;
   logic fill_end;
   logic beat;
   logic last_beat;

   function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v);
      bump = CNT_W'(v + 1'b1);
   endfunction

   bbi_fifo #(.WIDTH(DATA_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
      .CLK(CLK),
      .RST(RST),
      .IN_VALID(WR_VALID),
      .IN_DATA({WR_LAST, WR_DATA}),
      .IN_READY(WR_READY),
      .OUT_VALID(f_valid),
      .OUT_DATA(f_data),
      .OUT_READY(drain)
   );

   // filling goes on regardless of the send side, so bank b loads while a is on the bus
   assign drain = f_valid && !ready[fill_bank];
   // a packet closes on the marker or when the bank is full
   assign fill_end = drain && (f_data[DATA_W] || fill_cnt == CNT_W'(BANK_BYTES - 1));
   assign beat = (state == ST_SEND) && TX_READY;
   assign last_beat = beat && (bump(idx) == bank_len[send_bank]);

   always_ff @(posedge CLK) begin
      if (drain) begin
         bank_mem[fill_bank][fill_cnt[CNT_W-2:0]] <= f_data[DATA_W-1:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         fill_cnt <= CNT_RESET;
      end else if (fill_end) begin
         fill_cnt <= CNT_RESET;
      end else if (drain) begin
         fill_cnt <= bump(fill_cnt);
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         bank_len[0] <= CNT_RESET;
         bank_len[1] <= CNT_RESET;
      end else if (fill_end) begin
         bank_len[fill_bank] <= bump(fill_cnt);
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         fill_bank <= BANK_FIRST;
      end else if (fill_end) begin
         fill_bank <= !fill_bank;
      end
   end

   // set and clear never hit the same bank: filling only touches a bank that is not ready
   always_ff @(posedge CLK) begin
      if (RST) begin
         ready <= READY_RESET;
      end else begin
         if (fill_end) begin
            ready[fill_bank] <= 1'b1;
         end
         if (state == ST_WAIT && HS_ACK) begin
            ready[send_bank] <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         send_bank <= BANK_FIRST;
      end else if (state == ST_WAIT && HS_ACK) begin
         send_bank <= !send_bank;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (IN_TOKEN && ready[send_bank]) begin
               next_state = ST_SEND;
            end
         end
         ST_SEND: begin
            if (last_beat) begin
               next_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            // a missing ack leaves ready and data alone for a resend
            if (HS_ACK || HS_TIMEOUT) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // every send starts at byte zero, so a retry goes out whole
   always_ff @(posedge CLK) begin
      if (RST) begin
         idx <= CNT_RESET;
      end else if (state == ST_IDLE) begin
         idx <= CNT_RESET;
      end else if (beat && !last_beat) begin
         idx <= bump(idx);
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         TX_DATA <= '0;
         TX_LAST <= 1'b0;
      end else if (state == ST_IDLE) begin
         TX_DATA <= bank_mem[send_bank][0];
         TX_LAST <= (bank_len[send_bank] == CNT_W'(1));
      end else if (beat && !last_beat) begin
         TX_DATA <= bank_mem[send_bank][(CNT_W-1)'(bump(idx))];
         TX_LAST <= (CNT_W'(idx + 2'd2) == bank_len[send_bank]);
      end
   end

   assign TX_VALID = (state == ST_SEND);

   always_ff @(posedge CLK) begin
      if (RST) begin
         TX_NAK <= 1'b0;
      end else begin
         TX_NAK <= (state == ST_IDLE) && IN_TOKEN && !ready[send_bank];
      end
   end

   // reads 1 only with both banks waiting; one ready bank still shows 0
   assign PKT_READY_FLAG = &ready;

   // a free bank keeps the line up; both banks full takes it down
   always_ff @(posedge CLK) begin
      if (RST) begin
         IRQ_OUT <= 1'b0;
      end else begin
         IRQ_OUT <= TX_IRQ_EN && !(&ready);
      end
   end

   // bad receive: no notice, no handshake, host retries after its timeout
   always_ff @(posedge CLK) begin
      if (RST) begin
         RX_ACK <= 1'b0;
         RX_NOTIFY <= 1'b0;
      end else begin
         RX_ACK <= RX_DONE && !RX_BAD;
         RX_NOTIFY <= RX_DONE && !RX_BAD;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   a_irq_free_bank:
   assert property (TX_IRQ_EN && !(&ready) |=> IRQ_OUT)
      else $error("interrupt low with a free bank");

   a_irq_both_full:
   assert property (&ready |=> !IRQ_OUT)
      else $error("interrupt high with both banks full");

   a_flag_one_bank:
   assert property ($countones(ready) == 1 |-> !PKT_READY_FLAG)
      else $error("ready flag set with one bank");

   a_send_on_token:
   assert property (state == ST_IDLE && IN_TOKEN && ready[send_bank] |=> TX_VALID && idx == CNT_RESET)
      else $error("ready bank not sent on token");

   a_ack_clears:
   assert property (state == ST_WAIT && HS_ACK |=> !ready[$past(send_bank)])
      else $error("acked bank still ready");

   a_timeout_keeps:
   assert property (state == ST_WAIT && HS_TIMEOUT |=> ready[send_bank] && send_bank == $past(send_bank))
      else $error("unacked packet dropped");

   a_resend_full:
   assert property (state == ST_WAIT && HS_TIMEOUT ##[1:3] (state == ST_IDLE && IN_TOKEN)
      |=> TX_VALID && idx == CNT_RESET)
      else $error("retry not resent from start");

   a_alternate_banks:
   assert property (state == ST_WAIT && HS_ACK |=> send_bank != $past(send_bank))
      else $error("banks not alternated");

   a_rx_error_silent:
   assert property (RX_DONE && RX_BAD |=> !RX_ACK && !RX_NOTIFY)
      else $error("bad receive answered");

   a_fill_during_send:
   assert property (state == ST_SEND && f_valid && !ready[fill_bank] |-> drain)
      else $error("fill stalled by send");

   a_bank_bound:
   assert property (fill_cnt < CNT_W'(BANK_BYTES))
      else $error("bank overrun");

   c_both_full: cover property (&ready ##[1:200] (state == ST_WAIT && HS_ACK));
   c_retry: cover property (state == ST_WAIT && HS_TIMEOUT ##[1:20] TX_VALID);
   c_nak: cover property (TX_NAK);
endmodule

// file: hdl/bbi_pkg.sv
package bbi_pkg;
   localparam int DATA_W = 8;
   localparam int BANK_BYTES = 64;
   localparam int CNT_W = 7;
   localparam int FIFO_DEPTH = 16;
   localparam logic [CNT_W-1:0] CNT_RESET = 7'h00;
   localparam logic [1:0] READY_RESET = 2'h0;
   localparam logic BANK_FIRST = 1'b0;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SEND = 3'b010,
      ST_WAIT = 3'b100
   } bbi_state_type;
endpackage

// file: bench/bbi_host_model.sv
module bbi_host_model (
   input wire logic CLK,
   input wire logic TX_VALID,
   input wire logic [7:0] TX_DATA,
   input wire logic TX_LAST,
   input wire logic TX_NAK,
   output logic IN_TOKEN,
   output logic TX_READY,
   output logic HS_ACK,
   output logic HS_TIMEOUT
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got[$];
   logic nak_seen;
   initial begin
      IN_TOKEN = 1'b0;
      TX_READY = 1'b0;
      HS_ACK = 1'b0;
      HS_TIMEOUT = 1'b0;
   end
   // call just after a clock edge; ack low models a corrupted packet
   task automatic transfer(input logic ack, input int stall);
      int n;
      logic done;
      got.delete();
      nak_seen = 1'b0;
      done = 1'b0;
      n = 0;
      IN_TOKEN <= 1'b1;
      @(posedge CLK);
      IN_TOKEN <= 1'b0;
      while (!done && n < 600) begin
         TX_READY <= (n % (stall + 1)) == stall;
         @(posedge CLK);
         n++;
         if (TX_NAK === 1'b1) begin
            nak_seen = 1'b1;
            done = 1'b1;
         end
         if (TX_READY && TX_VALID === 1'b1) begin
            got.push_back(TX_DATA);
            done = TX_LAST;
         end
      end
      TX_READY <= 1'b0;
      if (!nak_seen) begin
         @(posedge CLK);
         HS_ACK <= ack;
         // host stays silent on a bad packet and only times out
         HS_TIMEOUT <= !ack;
         @(posedge CLK);
         HS_ACK <= 1'b0;
         HS_TIMEOUT <= 1'b0;
      end
   endtask
endmodule

// file: bench/test_dual_bank_bulk_in_endpoint.sv
module test_dual_bank_bulk_in_endpoint;
   timeunit 1ns;
   timeprecision 1ps;
   import bbi_pkg::*;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic WR_VALID = 1'b0;
   logic WR_LAST = 1'b0;
   logic TX_IRQ_EN = 1'b1;
   logic RX_DONE = 1'b0;
   logic RX_BAD = 1'b0;
   logic [DATA_W-1:0] WR_DATA = 8'h00;
   logic [DATA_W-1:0] TX_DATA;
   logic WR_READY, IRQ_OUT, PKT_READY_FLAG, IN_TOKEN, TX_VALID, TX_LAST, TX_READY, TX_NAK;
   logic HS_ACK, HS_TIMEOUT, RX_ACK, RX_NOTIFY;
   int err_total = 0;
   int checked = 0;
   int cycles = 0;
   always #4 CLK = ~CLK;
   bbi_top uut (.CLK, .RST, .WR_VALID, .WR_DATA, .WR_LAST, .WR_READY, .TX_IRQ_EN, .IRQ_OUT,
      .PKT_READY_FLAG, .IN_TOKEN, .TX_VALID, .TX_DATA, .TX_LAST, .TX_READY, .TX_NAK, .HS_ACK,
      .HS_TIMEOUT, .RX_DONE, .RX_BAD, .RX_ACK, .RX_NOTIFY);
   bbi_host_model host (.CLK, .TX_VALID, .TX_DATA, .TX_LAST, .TX_NAK, .IN_TOKEN, .TX_READY,
      .HS_ACK, .HS_TIMEOUT);
   task automatic stop_test();
      $display("checked %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge CLK);
   endtask
   // each byte is held until WR_READY reads 1 just after a clock edge
   task automatic write_bytes(input logic [7:0] base, input int n, input logic last);
      for (int i = 0; i < n; i++) begin
         WR_VALID <= 1'b1;
         WR_DATA <= base + 8'(i);
         WR_LAST <= last && (i == n - 1);
         do @(posedge CLK); while (WR_READY !== 1'b1);
      end
      WR_VALID <= 1'b0;
      WR_LAST <= 1'b0;
      @(posedge CLK);
   endtask
   task automatic check_pkt(input logic [7:0] base, input int n);
      cmp_val(16'(host.got.size()), 16'(n));
      for (int i = 0; i < host.got.size(); i++) begin
         cmp_val(16'(host.got[i]), 16'(base + 8'(i)));
      end
   endtask
   task automatic t_reset();
      idle(2);
      cmp_bit(IRQ_OUT, 1'b1);
      cmp_bit(PKT_READY_FLAG, 1'b0);
      host.transfer(1'b1, 0);
      cmp_bit(host.nak_seen, 1'b1);
   endtask
   task automatic t_two_banks();
      write_bytes(8'h10, 3, 1'b1);
      idle(4);
      cmp_bit(IRQ_OUT, 1'b1);
      cmp_bit(PKT_READY_FLAG, 1'b0);
      write_bytes(8'h40, 5, 1'b1);
      idle(4);
      cmp_bit(IRQ_OUT, 1'b0);
      cmp_bit(PKT_READY_FLAG, 1'b1);
      write_bytes(8'h80, 16, 1'b0);
      idle(2);
      cmp_bit(WR_READY, 1'b0);
   endtask
   // retry token follows the timeout closely so the resend assertion sees it
   task automatic t_retry();
      host.transfer(1'b0, 0);
      check_pkt(8'h10, 3);
      idle(2);
      cmp_bit(PKT_READY_FLAG, 1'b1);
      cmp_bit(IRQ_OUT, 1'b0);
      host.transfer(1'b1, 2);
      check_pkt(8'h10, 3);
      idle(20);
      cmp_bit(IRQ_OUT, 1'b1);
      cmp_bit(WR_READY, 1'b1);
      host.transfer(1'b1, 1);
      check_pkt(8'h40, 5);
   endtask
   task automatic t_forced_end();
      write_bytes(8'h90, 48, 1'b0);
      write_bytes(8'h20, 2, 1'b0);
      idle(4);
      cmp_bit(PKT_READY_FLAG, 1'b0);
      host.transfer(1'b1, 0);
      check_pkt(8'h80, 64);
      idle(3);
      cmp_bit(IRQ_OUT, 1'b1);
      write_bytes(8'h22, 1, 1'b1);
      host.transfer(1'b1, 0);
      check_pkt(8'h20, 3);
   endtask
   task automatic t_rx(input logic bad);
      RX_DONE <= 1'b1;
      RX_BAD <= bad;
      @(posedge CLK);
      RX_DONE <= 1'b0;
      RX_BAD <= 1'b0;
      @(posedge CLK);
      cmp_bit(RX_ACK, !bad);
      cmp_bit(RX_NOTIFY, !bad);
   endtask
   task automatic t_irq_off();
      TX_IRQ_EN <= 1'b0;
      idle(3);
      cmp_bit(IRQ_OUT, 1'b0);
      TX_IRQ_EN <= 1'b1;
      idle(3);
      cmp_bit(IRQ_OUT, 1'b1);
   endtask
   initial begin
      repeat (5) @(posedge CLK);
      RST <= 1'b0;
      t_reset();
      t_two_banks();
      t_retry();
      t_forced_end();
      t_rx(1'b1);
      t_rx(1'b0);
      t_irq_off();
      stop_test();
   end
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         stop_test();
      end
   end
endmodule
